// *** src/awr_pkg.sv ***
package awr_pkg;

    // register bus geometry
    localparam int ADDR_W = 12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONV_MODE = 8'h93;
    localparam logic [7:0] IDX_CLK_DIV = 8'h94;
    localparam logic [7:0] IDX_FILTER_MODE = 8'h97;
    localparam logic [7:0] IDX_RESULT_LOW = 8'h98;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h99;
    localparam logic [7:0] IDX_HOLD_CTRL = 8'h9B;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h9C;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h9D;

    localparam logic [ADDR_W-1:0] ADDR_CONV_MODE = {2'h0, IDX_CONV_MODE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CLK_DIV = {2'h0, IDX_CLK_DIV, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FILTER_MODE = {2'h0, IDX_FILTER_MODE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = {2'h0, IDX_RESULT_LOW, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RESULT_HIGH = {2'h0, IDX_RESULT_HIGH, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_HOLD_CTRL = {2'h0, IDX_HOLD_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

    // field positions
    localparam int MODE_ENABLE_BIT = 0;
    localparam int FM_READY_BIT = 0;
    localparam int FM_WRS_BIT = 2;
    localparam int HOLD_BIT = 0;
    localparam int STS_NEW_BIT = 0;
    localparam int STS_OVERRUN_BIT = 1;

    // reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [7:0] CLK_DIV_RST = 8'h00;

    // converter clock and decimation
    localparam logic [8:0] OSC_SPAN = 9'h100;
    localparam logic [13:0] WORD_SAMPLES = 14'hFA0;
    localparam logic [7:0] SCALE_MUL = 8'h7D;
    localparam logic [2:0] SCALE_SHIFT = 3'h4;
    localparam logic [15:0] POS_FULL = 16'h7A12;
    localparam logic [15:0] NEG_FULL = 16'h85EE;

    typedef struct packed {
        logic signed [13:0] acc;
        logic [13:0] cnt;
        logic long_q;
        logic [15:0] word;
        logic valid;
    } awr_dec_state_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic enable;
        logic [7:0] divider;
        logic wrs;
        logic hold;
        logic ready;
        logic [15:0] result;
        logic [1:0] sts;
        logic [1:0] msk;
        logic irq;
        logic [8:0] div_cnt;
        logic mod_clk;
        logic [2:0] sync;
        logic mod_bit;
    } awr_state_t;

    localparam awr_dec_state_t DEC_RST = '0;
    localparam awr_state_t STATE_RST = '0;

endpackage : awr_pkg

// *** src/awr_decimator.sv ***
`timescale 1ns/100ps
module awr_decimator #(
    parameter logic [13:0] SAMPLES = awr_pkg::WORD_SAMPLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic sample_tick,
    input wire logic sample_bit,
    input wire logic long_rate,
    output logic word_valid,
    output logic [15:0] word
);

    awr_pkg::awr_dec_state_t d_reg;
    awr_pkg::awr_dec_state_t d_next;
    logic signed [13:0] sum;
    logic [13:0] limit;
    logic signed [21:0] prod;
    logic signed [21:0] scaled;

    // boxcar accumulation over one word period, then scaling
    always_comb begin
        d_next = d_reg;
        d_next.valid = 1'b0;
        sum = d_reg.acc + (sample_bit ? 14'sh0001 : -14'sh0001);
        limit = d_reg.long_q ? {SAMPLES[12:0], 1'b0} : SAMPLES;
        prod = $signed({{8{sum[13]}}, sum}) * $signed({14'h0000, awr_pkg::SCALE_MUL});
        scaled = prod >>> (awr_pkg::SCALE_SHIFT + {2'h0, d_reg.long_q});
        if (!enable) begin
            d_next.acc = 14'sh0000;
            d_next.cnt = 14'h0000;
            d_next.long_q = long_rate;
        end else if (sample_tick) begin
            if (d_reg.cnt == limit - 14'h0001) begin
                d_next.valid = 1'b1;
                d_next.acc = 14'sh0000;
                d_next.cnt = 14'h0000;
                d_next.long_q = long_rate;
                if (scaled > $signed({6'h00, awr_pkg::POS_FULL})) begin
                    d_next.word = awr_pkg::POS_FULL;
                end else if (scaled < $signed({6'h3F, awr_pkg::NEG_FULL})) begin
                    d_next.word = awr_pkg::NEG_FULL;
                end else begin
                    d_next.word = scaled[15:0];
                end
            end else begin
                d_next.acc = sum;
                d_next.cnt = d_reg.cnt + 14'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            d_reg <= awr_pkg::DEC_RST;
        end else begin
            d_reg <= d_next;
        end
    end

    assign word_valid = d_reg.valid;
    assign word = d_reg.word;

endmodule : awr_decimator

// *** src/awr_result_rate.sv ***
`timescale 1ns/100ps
module awr_result_rate (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [awr_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [awr_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic mod_bit_in,
    output logic mod_clk_out,
    output logic mod_enable_out,
    output logic irq
);

    awr_pkg::awr_state_t s_reg;
    awr_pkg::awr_state_t s_next;
    logic sample_tick;
    logic dec_valid;
    logic [15:0] dec_word;
    logic [8:0] half_period;
    logic [7:0] rd_val;
    logic rd_ok;
    logic wr_ok;

    // decimation filter fed by the synchronised modulator bit
    awr_decimator #(
        .SAMPLES(awr_pkg::WORD_SAMPLES)
    ) u_decimator (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(s_reg.enable),
        .sample_tick(sample_tick),
        .sample_bit(s_reg.mod_bit),
        .long_rate(s_reg.wrs),
        .word_valid(dec_valid),
        .word(dec_word)
    );

    // read data selection from the live read address input, not a captured copy
    always_comb begin
        rd_val = 8'h00;
        rd_ok = 1'b1;
        case (araddr)
            awr_pkg::ADDR_CONV_MODE: begin
                rd_val[awr_pkg::MODE_ENABLE_BIT] = s_reg.enable;
            end
            awr_pkg::ADDR_CLK_DIV: begin
                rd_val = s_reg.divider;
            end
            awr_pkg::ADDR_FILTER_MODE: begin
                rd_val[awr_pkg::FM_READY_BIT] = s_reg.ready;
                rd_val[awr_pkg::FM_WRS_BIT] = s_reg.wrs;
            end
            awr_pkg::ADDR_RESULT_LOW: begin
                rd_val = s_reg.result[7:0];
            end
            awr_pkg::ADDR_RESULT_HIGH: begin
                rd_val = s_reg.result[15:8];
            end
            awr_pkg::ADDR_HOLD_CTRL: begin
                rd_val[awr_pkg::HOLD_BIT] = s_reg.hold;
            end
            awr_pkg::ADDR_IRQ_STATUS: begin
                rd_val = {6'h00, s_reg.sts};
            end
            awr_pkg::ADDR_IRQ_MASK: begin
                rd_val = {6'h00, s_reg.msk};
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // write address decode of the held write address
    always_comb begin
        case (s_reg.waddr)
            awr_pkg::ADDR_CONV_MODE,
            awr_pkg::ADDR_CLK_DIV,
            awr_pkg::ADDR_FILTER_MODE,
            awr_pkg::ADDR_RESULT_LOW,
            awr_pkg::ADDR_RESULT_HIGH,
            awr_pkg::ADDR_HOLD_CTRL,
            awr_pkg::ADDR_IRQ_STATUS,
            awr_pkg::ADDR_IRQ_MASK: begin
                wr_ok = 1'b1;
            end
            default: begin
                wr_ok = 1'b0;
            end
        endcase
    end

    // whole next-state computation
    always_comb begin
        s_next = s_reg;
        sample_tick = 1'b0;
        half_period = awr_pkg::OSC_SPAN - {1'b0, s_reg.divider};

        // three-stage pin synchroniser, change taken when stages 2 and 3 agree
        s_next.sync = {s_reg.sync[1:0], mod_bit_in};
        if (s_reg.sync[1] == s_reg.sync[2]) begin
            s_next.mod_bit = s_reg.sync[2];
        end

        // converter clock runs only when enabled
        if (!s_reg.enable) begin
            s_next.div_cnt = 9'h000;
            s_next.mod_clk = 1'b0;
        // toggle every half period
        // compare with >= so a divider raised mid-count cannot skip the wrap point
        end else if (s_reg.div_cnt >= half_period - 9'h001) begin
            s_next.div_cnt = 9'h000;
            s_next.mod_clk = ~s_reg.mod_clk;
            sample_tick = ~s_reg.mod_clk; // one sample per rising edge
        end else begin
            s_next.div_cnt = s_reg.div_cnt + 9'h001;
        end

        // write address and data channels, taken in either order
        if (awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.waddr = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.wbyte = wdata[7:0];
            s_next.wlane = wstrb[0];
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // register write once both halves are held
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = wr_ok ? awr_pkg::RESP_OKAY : awr_pkg::RESP_SLVERR;
            if (s_reg.wlane) begin
                case (s_reg.waddr)
                    awr_pkg::ADDR_CONV_MODE: begin
                        s_next.enable = s_reg.wbyte[awr_pkg::MODE_ENABLE_BIT];
                    end
                    awr_pkg::ADDR_CLK_DIV: begin
                        s_next.divider = s_reg.wbyte;
                    end
                    awr_pkg::ADDR_FILTER_MODE: begin
                        s_next.wrs = s_reg.wbyte[awr_pkg::FM_WRS_BIT];
                        if (!s_reg.wbyte[awr_pkg::FM_READY_BIT]) begin
                            s_next.ready = 1'b0;
                        end
                    end
                    awr_pkg::ADDR_HOLD_CTRL: begin
                        s_next.hold = s_reg.wbyte[awr_pkg::HOLD_BIT];
                    end
                    awr_pkg::ADDR_IRQ_STATUS: begin
                        s_next.sts = s_reg.sts & ~s_reg.wbyte[1:0]; // write one to clear
                    end
                    awr_pkg::ADDR_IRQ_MASK: begin
                        s_next.msk = s_reg.wbyte[1:0];
                    end
                    default: begin
                        s_next.result = s_reg.result;
                    end
                endcase
            end
        end

        // new word from the filter; applied after writes so a set wins
        if (dec_valid) begin
            if (!s_reg.hold) begin
                s_next.result = dec_word;
                if (s_next.ready) begin
                    s_next.sts[awr_pkg::STS_OVERRUN_BIT] = 1'b1;
                end
                s_next.ready = 1'b1;
                s_next.sts[awr_pkg::STS_NEW_BIT] = 1'b1;
            end
        end

        // read channel, answer one cycle after the address is taken
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rdata = {24'h000000, rd_val};
            s_next.rresp = rd_ok ? awr_pkg::RESP_OKAY : awr_pkg::RESP_SLVERR;
        end

        // handshake readies follow the pending transfers
        s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
        s_next.wready = ~s_next.w_got & ~s_next.bvalid;
        s_next.arready = ~s_next.rvalid;

        // level interrupt from unmasked sticky bits
        s_next.irq = |(s_next.sts & s_next.msk);
    end

    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= awr_pkg::STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register
    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;
    assign mod_clk_out = s_reg.mod_clk;
    assign mod_enable_out = s_reg.enable;
    assign irq = s_reg.irq;

endmodule : awr_result_rate

// *** tb/awr_modulator_model.sv ***
`timescale 1ns/100ps
module awr_modulator_model (
    input wire logic aclk,
    input wire logic mod_clk,
    input wire logic enable,
    input wire logic level,
    output logic bit_out
);
    logic clk_q = 1'h0;
    initial bit_out = 1'h0;
    // level pins the bitstream; full scale used on purpose for the clamp checks
    // new bit after each rising converter clock; junk toggling while idle
    always @(posedge aclk) begin
        clk_q <= mod_clk;
        if (!enable) bit_out <= ~bit_out;
        else if (mod_clk && !clk_q) bit_out <= level;
    end
endmodule : awr_modulator_model

// *** tb/awr_result_rate_checker.sv ***
`timescale 1ns/100ps
module awr_result_rate_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic mod_clk_out,
    input wire logic mod_enable_out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // handshake steps and two disabled cycles
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_taken;
        arvalid && arready;
    endsequence
    sequence s_idle2;
        !mod_enable_out ##1 !mod_enable_out;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |-> ##2 bvalid)
        else $error("write answer not two cycles after handshake");
    AST_RD_ANSWER: assert property (s_rd_taken |=> rvalid)
        else $error("read answer late");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    AST_R_BYTE: assert property (rvalid |-> rdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_ERR_ZERO: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
        else $error("error read carries data");
    AST_AR_BLOCK: assert property (rvalid |-> !arready)
        else $error("read address accepted during answer");
    AST_W_BLOCK: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted during answer");
    AST_CLK_IDLE: assert property (s_idle2 |-> !mod_clk_out)
        else $error("converter clock runs while disabled");
    AST_CLK_EN: assert property ($rose(mod_clk_out) |-> mod_enable_out)
        else $error("converter clock rose while disabled");
endmodule : awr_result_rate_checker

// *** tb/test_awr_result_rate.sv ***
`timescale 1ns/100ps
module test_awr_result_rate;
    localparam logic [11:0] MODE = awr_pkg::ADDR_CONV_MODE;
    localparam logic [11:0] FM = awr_pkg::ADDR_FILTER_MODE;
    localparam logic [11:0] LOW = awr_pkg::ADDR_RESULT_LOW;
    localparam logic [11:0] HIGH = awr_pkg::ADDR_RESULT_HIGH;
    localparam logic [11:0] STS = awr_pkg::ADDR_IRQ_STATUS;
    localparam logic [11:0] MSK = awr_pkg::ADDR_IRQ_MASK;
    localparam int PER = 2 * 4000;
    logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, level = 1'h1;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, mod_bit_in, mod_clk_out, mod_enable_out, irq;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata;
    logic [7:0] got;
    int n_fail = 0, n_compared = 0, cyc = 0, t0 = 0;

    always #20 aclk = ~aclk;
    awr_result_rate i_dut (.*);
    awr_modulator_model i_mod (.aclk(aclk), .mod_clk(mod_clk_out), .enable(mod_enable_out),
        .level(level), .bit_out(mod_bit_in));
    // cycle count and hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail++;
            $display("ERROR %0t run too long", $time);
            conclude();
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic chk_near(input int g, input int e, input int tol);
        n_compared++;
        if (g < e - tol || g > e + tol) begin
            n_fail++;
            $display("ERROR %0t cycles %0d want %0d", $time, g, e);
        end
    endtask : chk_near
    // write one byte; release each channel when taken
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic aw_hs, w_hs, b_hs;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(negedge aclk);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bvalid === 1'h1;
            rs = bresp;
            @(posedge aclk);
            if (aw_hs) awvalid <= 1'h0;
            if (w_hs) wvalid <= 1'h0;
            if (b_hs) begin
                bready <= 1'h0;
                break;
            end
        end
    endtask : wr
    task automatic rd_reg(input logic [11:0] a);
        logic ar_hs, r_hs;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(negedge aclk);
            ar_hs = arvalid && arready;
            r_hs = rvalid === 1'h1;
            got = rdata[7:0];
            rs = rresp;
            @(posedge aclk);
            if (ar_hs) arvalid <= 1'h0;
            if (r_hs) begin
                rready <= 1'h0;
                break;
            end
        end
    endtask : rd_reg
    task automatic wait_bit(input logic [11:0] a, input int b);
        do rd_reg(a); while (got[b] !== 1'h1);
    endtask : wait_bit
    task automatic clk_per(input int e);
        @(posedge mod_clk_out);
        t0 = cyc;
        @(posedge mod_clk_out);
        chk_near(cyc - t0, e, 0);
    endtask : clk_per
    task automatic t_reset();
        rd_reg(LOW);
        chk(got, 8'h00);
        rd_reg(HIGH);
        chk(got, 8'h00);
        rd_reg(FM);
        chk(got, 8'h00);
        rd_reg(12'h000);
        chk({6'h0, rs}, 8'h02);
        wr(12'h000, 8'hFF);
        chk({6'h0, rs}, 8'h02);
    endtask : t_reset
    task automatic t_clock();
        chk({7'h0, mod_clk_out}, 8'h00);
        wr(awr_pkg::ADDR_CLK_DIV, 8'hFE);
        wr(FM, 8'h00);
        wr(MODE, 8'h01);
        chk({7'h0, mod_enable_out}, 8'h01);
        clk_per(4);
        wr(awr_pkg::ADDR_CLK_DIV, 8'hFF);
        clk_per(2);
    endtask : t_clock
    task automatic t_words();
        wait_bit(FM, 0);
        t0 = cyc;
        wr(FM, 8'h00);
        rd_reg(FM);
        chk(got, 8'h00);
        wait_bit(FM, 0);
        chk_near(cyc - t0, PER, 24);
        rd_reg(HIGH);
        chk(got, 8'h7A);
        rd_reg(LOW);
        chk(got, 8'h12);
        rd_reg(FM);
        chk(got, 8'h01);
        wr(LOW, 8'h55);
        chk({6'h0, rs}, 8'h00);
        wr(HIGH, 8'h55);
        rd_reg(LOW);
        chk(got, 8'h12);
        rd_reg(HIGH);
        chk(got, 8'h7A);
        wr(MSK, 8'h01);
        @(negedge aclk);
        chk({7'h0, irq}, 8'h01);
        wr(STS, 8'h03);
        @(negedge aclk);
        chk({7'h0, irq}, 8'h00);
    endtask : t_words
    task automatic t_overwrite();
        wr(MSK, 8'h00);
        level <= 1'h0;
        wr(STS, 8'h03);
        wait_bit(STS, 0);
        wr(STS, 8'h03);
        wait_bit(STS, 0);
        chk({7'h0, irq}, 8'h00);
        chk(got, 8'h03);
        rd_reg(HIGH);
        chk(got, 8'h85);
        rd_reg(LOW);
        chk(got, 8'hEE);
    endtask : t_overwrite
    task automatic t_hold();
        wr(awr_pkg::ADDR_HOLD_CTRL, 8'h01);
        level <= 1'h1;
        wr(FM, 8'h00);
        repeat (PER + 1000) @(posedge aclk);
        rd_reg(FM);
        chk(got, 8'h00);
        rd_reg(HIGH);
        chk(got, 8'h85);
        wr(awr_pkg::ADDR_HOLD_CTRL, 8'h00);
        t0 = cyc;
        wait_bit(FM, 0);
        chk_near(cyc - t0, PER / 2, PER / 2 + 50);
        rd_reg(HIGH);
        chk(got, 8'h7A);
    endtask : t_hold
    task automatic t_rate();
        wr(FM, 8'h04);
        wait_bit(FM, 0);
        t0 = cyc;
        wr(FM, 8'h04);
        wait_bit(FM, 0);
        chk_near(cyc - t0, 2 * PER, 24);
        chk(got, 8'h05);
        rd_reg(HIGH);
        chk(got, 8'h7A);
    endtask : t_rate
    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_clock();
        t_words();
        t_overwrite();
        t_hold();
        t_rate();
        conclude();
    end
endmodule : test_awr_result_rate
bind awr_result_rate awr_result_rate_checker i_chk (.*);
